/* shared/hac_consts.svh */
`ifndef HAC_CONSTS_SVH
`define HAC_CONSTS_SVH

`define HAC_ADDR_TEMP_RESULT    8'hd7
`define HAC_ADDR_CONV_START     8'hd8
`define HAC_ADDR_BATT_RESULT    8'hdf
`define HAC_ADDR_VDC_RESULT     8'hef
`define HAC_ADDR_DELTA_CFG      8'hf3
`define HAC_ADDR_STROBE_CFG     8'hf9
`define HAC_ADDR_BATT_THRESH    8'hfa
`define HAC_BIT_BASE            8'hd8
`define HAC_BIT_TOP             8'hdf
`define HAC_GO_BATT             0
`define HAC_GO_TEMP             1
`define HAC_GO_VDC              2
`define HAC_GO_PLL_ACK          7
`define HAC_VDC_DELTA_LSB       0
`define HAC_TEMP_DELTA_LSB      3
`define HAC_TEMP_PER_LSB        0
`define HAC_BATT_PER_LSB        2
`define HAC_VDC_PER_LSB         4
`define HAC_RST_BYTE            8'h00
`define HAC_RST_GO              3'h0
`define HAC_RST_CFG             6'h00
`define HAC_DELTA_OFF           3'h0
`define HAC_DELTA_ALL           3'h7
`define HAC_TEMP_PER_LONG       5'h08
`define HAC_TEMP_PER_MID        5'h02
`define HAC_BATT_PER_LONG       5'h10
`define HAC_BATT_PER_MID        5'h04
`define HAC_VDC_PER_LONG        5'h08
`define HAC_VDC_PER_MID         5'h02
`define HAC_PER_SHORT           5'h01
`define HAC_MINUTE_S            36'h3c
`define HAC_CLK_HZ              36'h5f5e100
`define HAC_MINUTE_CYCLES       (`HAC_MINUTE_S * `HAC_CLK_HZ)

`endif

/* shared/hac_pkg.sv */
package hac_pkg;

    typedef enum logic [1:0] {
        HAC_IDLE,
        HAC_REQ,
        HAC_CONV
    } hac_chan_st_e;

    // Answer side of one converter handshake
    typedef struct packed {
        logic       ack;
        logic       done;
        logic [7:0] result;
    } hac_conv_in_s;

endpackage

/* hw/hac_period_timer.sv */
`timescale 1ns/1ns
`include "hac_consts.svh"

module hac_period_timer #(
    parameter logic [4:0] LONG_MIN = 5'h08,
    parameter logic [4:0] MID_MIN  = 5'h02
) (
    input  wire logic       i_mclk,
    input  wire logic       i_rst_b,
    input  wire logic       i_minute_tick,
    input  wire logic [1:0] i_period,
    output logic            o_strobe
);

    logic [4:0] cnt_q;
    logic [4:0] lim;

    always_comb begin
        case (i_period)
            2'h1:    lim = LONG_MIN;
            2'h2:    lim = MID_MIN;
            default: lim = `HAC_PER_SHORT;
        endcase
    end

    // Code zero keeps the timer idle
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q    <= 5'h00;
            o_strobe <= 1'b0;
        end else if (i_period == 2'h0) begin
            cnt_q    <= 5'h00;
            o_strobe <= 1'b0;
        end else if (i_minute_tick) begin
            if (cnt_q + 5'h01 >= lim) begin
                cnt_q    <= 5'h00;
                o_strobe <= 1'b1;
            end else begin
                cnt_q    <= cnt_q + 5'h01;
                o_strobe <= 1'b0;
            end
        end else begin
            o_strobe <= 1'b0;
        end
    end

endmodule // hac_period_timer

/* hw/hac_conv_chan.sv */
`timescale 1ns/1ns
`include "hac_consts.svh"

module hac_conv_chan #(
    parameter bit THRESH_MODE = 1'b0
) (
    input  wire logic              i_mclk,
    input  wire logic              i_rst_b,
    input  wire logic              i_sw_go,
    input  wire logic              i_bg_strobe,
    input  wire logic [2:0]        i_delta,
    input  wire logic [7:0]        i_thresh,
    input  hac_pkg::hac_conv_in_s  i_conv,
    output logic                   o_req,
    output logic                   o_taken,
    output logic                   o_event,
    output logic [7:0]             o_data
);

    hac_pkg::hac_chan_st_e st_q;
    logic                  bg_pend_q;
    logic                  single_q;
    logic [7:0]            last_q;
    logic                  hit;

    function automatic logic delta_hit(input logic [7:0] a, input logic [7:0] b, input logic [2:0] code);
        logic [7:0] d;
        d = (a > b) ? (a - b) : (b - a);
        if (code == `HAC_DELTA_OFF) begin
            delta_hit = 1'b0;
        end else if (code == `HAC_DELTA_ALL) begin
            delta_hit = 1'b1;
        end else begin
            delta_hit = d > {5'h00, code};
        end
    endfunction

    always_comb begin
        if (THRESH_MODE) begin
            hit = i_conv.result < i_thresh;
        end else begin
            hit = delta_hit(i_conv.result, last_q, i_delta);
        end
    end

    assign o_taken = (st_q == hac_pkg::HAC_REQ) && i_conv.ack && i_sw_go;

    // A new strobe wins over the clear
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bg_pend_q <= 1'b0;
        end else if (i_bg_strobe) begin
            bg_pend_q <= 1'b1;
        end else if (st_q == hac_pkg::HAC_REQ && i_conv.ack) begin
            bg_pend_q <= 1'b0;
        end
    end

    // Converter handshake
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_q     <= hac_pkg::HAC_IDLE;
            o_req    <= 1'b0;
            single_q <= 1'b0;
            o_event  <= 1'b0;
            o_data   <= `HAC_RST_BYTE;
        end else begin
            o_event <= 1'b0;
            case (st_q)
                hac_pkg::HAC_IDLE: begin
                    if (i_sw_go || bg_pend_q) begin
                        st_q  <= hac_pkg::HAC_REQ;
                        o_req <= 1'b1;
                    end
                end
                hac_pkg::HAC_REQ: begin
                    if (i_conv.ack) begin
                        st_q     <= hac_pkg::HAC_CONV;
                        o_req    <= 1'b0;
                        single_q <= i_sw_go;
                    end
                end
                hac_pkg::HAC_CONV: begin
                    if (i_conv.done) begin
                        st_q    <= hac_pkg::HAC_IDLE;
                        o_event <= single_q || hit;
                        o_data  <= i_conv.result;
                    end
                end
                default: begin
                    st_q  <= hac_pkg::HAC_IDLE;
                    o_req <= 1'b0;
                end
            endcase
        end
    end

    // Last reported value follows reported events only
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            last_q <= `HAC_RST_BYTE;
        end else if (st_q == hac_pkg::HAC_CONV && i_conv.done && (single_q || hit)) begin
            last_q <= i_conv.result;
        end
    end

endmodule // hac_conv_chan

/* hw/hac_top.sv */
`timescale 1ns/1ns
`include "hac_consts.svh"

// How it works
// - Voltage delta bits 2:0; 0 off, 1-6 LSB threshold, 7 every sample.
// - Background temperature interrupts when change from last reported exceeds delta.
// - Start bit 2 requests voltage conversion; clears when converter accepts.
// - Start bit 1 requests temperature conversion; clears when converter accepts.
// - Start bit 0 requests battery conversion; clears when converter accepts.
// - Writing one to start bit 7 pulses the PLL fault clear.
// - Battery result below threshold register raises the battery interrupt.
// - Voltage result register loads on a voltage event or a software write.
// - Battery result register loads on a battery event or a software write.
// - Temperature result register loads on a temperature event or a software write.
// - Software temperature conversion always loads result and interrupts.
// - Periodic temperature sampling off after reset until interval nonzero.
// - Temperature result kept as 8-bit unsigned value.
// - Temperature delta bits 5:3; 0 off, 1-6 LSB threshold, 7 every sample.
// - Temperature interval bits 1:0: off, 8, 2, 1 minutes.
// - Background voltage change beyond delta sets the voltage-change flag.
// - Background battery below threshold sets the low-battery flag.
module hac_top #(
    parameter logic [35:0] MINUTE_CYCLES = `HAC_MINUTE_CYCLES
) (
    input  wire logic              i_mclk,
    input  wire logic              i_rst_b,
    input  wire logic [7:0]        i_sfr_addr,
    input  wire logic [7:0]        i_sfr_wdata,
    input  wire logic              i_sfr_wr,
    input  wire logic [7:0]        i_bit_addr,
    input  wire logic              i_bit_wdata,
    input  wire logic              i_bit_wr,
    input  hac_pkg::hac_conv_in_s  i_temp_conv,
    input  hac_pkg::hac_conv_in_s  i_batt_conv,
    input  hac_pkg::hac_conv_in_s  i_vdc_conv,
    output logic [7:0]             o_sfr_rdata,
    output logic                   o_bit_rdata,
    output logic                   o_temp_req,
    output logic                   o_batt_req,
    output logic                   o_vdc_req,
    output logic                   o_temp_irq,
    output logic                   o_low_battery_flag_set,
    output logic                   o_voltage_change_flag_set,
    output logic                   o_pll_fault_clr
);

    logic [2:0]  go_q;
    logic [2:0]  go_d;
    logic [2:0]  taken;
    logic [7:0]  temperature_result_q;
    logic [7:0]  battery_result_q;
    logic [7:0]  ext_voltage_result_q;
    logic [5:0]  change_delta_config_q;
    logic [5:0]  strobe_period_config_q;
    logic [7:0]  battery_low_threshold_q;
    logic [35:0] minute_cnt_q;
    logic        minute_tick_q;
    logic [2:0]  bg_strobe;
    logic [2:0]  chan_event;
    logic [7:0]  temp_data;
    logic [7:0]  batt_data;
    logic [7:0]  vdc_data;
    logic [7:0]  start_view;
    logic        wr_start;
    logic        bit_hit;
    logic [2:0]  bit_idx;

    function automatic logic byte_wr(input logic wr, input logic [7:0] addr, input logic [7:0] target);
        byte_wr = wr && (addr == target);
    endfunction

    assign wr_start   = byte_wr(i_sfr_wr, i_sfr_addr, `HAC_ADDR_CONV_START);
    assign bit_hit    = (i_bit_addr >= `HAC_BIT_BASE) && (i_bit_addr <= `HAC_BIT_TOP);
    assign bit_idx    = 3'(i_bit_addr - `HAC_BIT_BASE);
    assign start_view = {4'h0, 1'b0, go_q};

    // Go bits: a software set wins over the converter's clear
    always_comb begin
        go_d = go_q & ~taken;
        if (wr_start) begin
            go_d = i_sfr_wdata[2:0];
        end else if (i_bit_wr && bit_hit && bit_idx <= 3'h2) begin
            go_d[bit_idx[1:0]] = i_bit_wdata;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            go_q <= `HAC_RST_GO;
        end else begin
            go_q <= go_d;
        end
    end

    // PLL fault acknowledge is a write-one pulse, reads back zero
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pll_fault_clr <= 1'b0;
        end else begin
            o_pll_fault_clr <= (wr_start && i_sfr_wdata[`HAC_GO_PLL_ACK]) ||
                               (i_bit_wr && bit_hit && bit_idx == 3'h7 && i_bit_wdata);
        end
    end

    // Configuration registers; reserved bits are not stored
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            change_delta_config_q   <= `HAC_RST_CFG;
            strobe_period_config_q  <= `HAC_RST_CFG;
            battery_low_threshold_q <= `HAC_RST_BYTE;
        end else begin
            if (byte_wr(i_sfr_wr, i_sfr_addr, `HAC_ADDR_DELTA_CFG)) begin
                change_delta_config_q <= i_sfr_wdata[5:0];
            end
            if (byte_wr(i_sfr_wr, i_sfr_addr, `HAC_ADDR_STROBE_CFG)) begin
                strobe_period_config_q <= i_sfr_wdata[5:0];
            end
            if (byte_wr(i_sfr_wr, i_sfr_addr, `HAC_ADDR_BATT_THRESH)) begin
                battery_low_threshold_q <= i_sfr_wdata;
            end
        end
    end

    // Result registers: an event load wins over a software write
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            temperature_result_q <= `HAC_RST_BYTE;
        end else if (chan_event[`HAC_GO_TEMP]) begin
            temperature_result_q <= temp_data;
        end else if (byte_wr(i_sfr_wr, i_sfr_addr, `HAC_ADDR_TEMP_RESULT)) begin
            temperature_result_q <= i_sfr_wdata;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            battery_result_q <= `HAC_RST_BYTE;
        end else if (chan_event[`HAC_GO_BATT]) begin
            battery_result_q <= batt_data;
        end else if (byte_wr(i_sfr_wr, i_sfr_addr, `HAC_ADDR_BATT_RESULT)) begin
            battery_result_q <= i_sfr_wdata;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ext_voltage_result_q <= `HAC_RST_BYTE;
        end else if (chan_event[`HAC_GO_VDC]) begin
            ext_voltage_result_q <= vdc_data;
        end else if (byte_wr(i_sfr_wr, i_sfr_addr, `HAC_ADDR_VDC_RESULT)) begin
            ext_voltage_result_q <= i_sfr_wdata;
        end
    end

    // Registered read data; unmapped addresses read zero
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_sfr_rdata <= `HAC_RST_BYTE;
            o_bit_rdata <= 1'b0;
        end else begin
            if (i_sfr_addr == `HAC_ADDR_TEMP_RESULT) begin
                o_sfr_rdata <= temperature_result_q;
            end else if (i_sfr_addr == `HAC_ADDR_CONV_START) begin
                o_sfr_rdata <= start_view;
            end else if (i_sfr_addr == `HAC_ADDR_BATT_RESULT) begin
                o_sfr_rdata <= battery_result_q;
            end else if (i_sfr_addr == `HAC_ADDR_VDC_RESULT) begin
                o_sfr_rdata <= ext_voltage_result_q;
            end else if (i_sfr_addr == `HAC_ADDR_DELTA_CFG) begin
                o_sfr_rdata <= {2'h0, change_delta_config_q};
            end else if (i_sfr_addr == `HAC_ADDR_STROBE_CFG) begin
                o_sfr_rdata <= {2'h0, strobe_period_config_q};
            end else if (i_sfr_addr == `HAC_ADDR_BATT_THRESH) begin
                o_sfr_rdata <= battery_low_threshold_q;
            end else begin
                o_sfr_rdata <= `HAC_RST_BYTE;
            end
            o_bit_rdata <= bit_hit && start_view[bit_idx];
        end
    end

    // Minute tick shared by the three period timers
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            minute_cnt_q  <= 36'h0;
            minute_tick_q <= 1'b0;
        end else if (minute_cnt_q >= MINUTE_CYCLES - 36'h1) begin
            minute_cnt_q  <= 36'h0;
            minute_tick_q <= 1'b1;
        end else begin
            minute_cnt_q  <= minute_cnt_q + 36'h1;
            minute_tick_q <= 1'b0;
        end
    end

    hac_period_timer #(
        .LONG_MIN (`HAC_TEMP_PER_LONG),
        .MID_MIN  (`HAC_TEMP_PER_MID)
    ) u_temp_timer (
        .i_mclk        (i_mclk),
        .i_rst_b       (i_rst_b),
        .i_minute_tick (minute_tick_q),
        .i_period      (strobe_period_config_q[`HAC_TEMP_PER_LSB +: 2]),
        .o_strobe      (bg_strobe[`HAC_GO_TEMP])
    );

    hac_period_timer #(
        .LONG_MIN (`HAC_BATT_PER_LONG),
        .MID_MIN  (`HAC_BATT_PER_MID)
    ) u_batt_timer (
        .i_mclk        (i_mclk),
        .i_rst_b       (i_rst_b),
        .i_minute_tick (minute_tick_q),
        .i_period      (strobe_period_config_q[`HAC_BATT_PER_LSB +: 2]),
        .o_strobe      (bg_strobe[`HAC_GO_BATT])
    );

    hac_period_timer #(
        .LONG_MIN (`HAC_VDC_PER_LONG),
        .MID_MIN  (`HAC_VDC_PER_MID)
    ) u_vdc_timer (
        .i_mclk        (i_mclk),
        .i_rst_b       (i_rst_b),
        .i_minute_tick (minute_tick_q),
        .i_period      (strobe_period_config_q[`HAC_VDC_PER_LSB +: 2]),
        .o_strobe      (bg_strobe[`HAC_GO_VDC])
    );

    hac_conv_chan #(.THRESH_MODE(1'b0)) u_temp_chan (
        .i_mclk      (i_mclk),
        .i_rst_b     (i_rst_b),
        .i_sw_go     (go_q[`HAC_GO_TEMP]),
        .i_bg_strobe (bg_strobe[`HAC_GO_TEMP]),
        .i_delta     (change_delta_config_q[`HAC_TEMP_DELTA_LSB +: 3]),
        .i_thresh    (`HAC_RST_BYTE),
        .i_conv      (i_temp_conv),
        .o_req       (o_temp_req),
        .o_taken     (taken[`HAC_GO_TEMP]),
        .o_event     (chan_event[`HAC_GO_TEMP]),
        .o_data      (temp_data)
    );

    hac_conv_chan #(.THRESH_MODE(1'b1)) u_batt_chan (
        .i_mclk      (i_mclk),
        .i_rst_b     (i_rst_b),
        .i_sw_go     (go_q[`HAC_GO_BATT]),
        .i_bg_strobe (bg_strobe[`HAC_GO_BATT]),
        .i_delta     (`HAC_DELTA_OFF),
        .i_thresh    (battery_low_threshold_q),
        .i_conv      (i_batt_conv),
        .o_req       (o_batt_req),
        .o_taken     (taken[`HAC_GO_BATT]),
        .o_event     (chan_event[`HAC_GO_BATT]),
        .o_data      (batt_data)
    );

    hac_conv_chan #(.THRESH_MODE(1'b0)) u_vdc_chan (
        .i_mclk      (i_mclk),
        .i_rst_b     (i_rst_b),
        .i_sw_go     (go_q[`HAC_GO_VDC]),
        .i_bg_strobe (bg_strobe[`HAC_GO_VDC]),
        .i_delta     (change_delta_config_q[`HAC_VDC_DELTA_LSB +: 3]),
        .i_thresh    (`HAC_RST_BYTE),
        .i_conv      (i_vdc_conv),
        .o_req       (o_vdc_req),
        .o_taken     (taken[`HAC_GO_VDC]),
        .o_event     (chan_event[`HAC_GO_VDC]),
        .o_data      (vdc_data)
    );

    // Event pulses leave the block from channel flip-flops
    assign o_temp_irq                = chan_event[`HAC_GO_TEMP];
    assign o_low_battery_flag_set    = chan_event[`HAC_GO_BATT];
    assign o_voltage_change_flag_set = chan_event[`HAC_GO_VDC];

endmodule // hac_top

/* bench/hac_conv_model.sv */
`timescale 1ns/1ns

module hac_conv_model (
    input  wire logic             i_mclk,
    input  wire logic             i_rst_b,
    input  wire logic             i_req,
    input  wire logic [3:0]       i_ack_dly,
    input  wire logic [3:0]       i_conv_dly,
    input  wire logic [7:0]       i_result,
    output hac_pkg::hac_conv_in_s o_conv
);
    logic       busy;
    logic [3:0] cnt;

    // Result lines toggle while not valid
    always @(negedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            {busy, cnt, o_conv} = '0;
        end else begin
            o_conv.ack = 1'b0;
            o_conv.done = 1'b0;
            o_conv.result = ~o_conv.result;
            if (!busy && i_req) begin
                if (cnt >= i_ack_dly) begin
                    o_conv.ack = 1'b1;
                    {busy, cnt} = {1'b1, 4'h0};
                end else begin
                    cnt = cnt + 4'h1;
                end
            end else if (busy) begin
                if (cnt >= i_conv_dly) begin
                    o_conv.done = 1'b1;
                    o_conv.result = i_result;
                    {busy, cnt} = {1'b0, 4'h0};
                end else begin
                    cnt = cnt + 4'h1;
                end
            end
        end
    end
endmodule // hac_conv_model

/* bench/hac_top_chk.sv */
`timescale 1ns/1ns

module hac_top_chk #(
    parameter logic [35:0] MINUTE_CYCLES = 36'h28
) (
    input wire logic            i_mclk,
    input wire logic            i_rst_b,
    input wire logic [7:0]      i_sfr_addr,
    input wire logic [7:0]      i_sfr_wdata,
    input wire logic            i_sfr_wr,
    input wire logic [7:0]      i_bit_addr,
    input wire logic            i_bit_wdata,
    input wire logic            i_bit_wr,
    input hac_pkg::hac_conv_in_s i_temp_conv,
    input hac_pkg::hac_conv_in_s i_batt_conv,
    input hac_pkg::hac_conv_in_s i_vdc_conv,
    input wire logic            o_bit_rdata,
    input wire logic            o_temp_req,
    input wire logic            o_temp_irq,
    input wire logic            o_low_battery_flag_set,
    input wire logic            o_voltage_change_flag_set,
    input wire logic            o_pll_fault_clr
);
    logic [7:0] thr_q;
    logic       pll_wr;
    logic       start_wr;

    assign start_wr = i_sfr_wr && i_sfr_addr == 8'hd8;
    assign pll_wr = (start_wr && i_sfr_wdata[7]) || (i_bit_wr && i_bit_addr == 8'hdf && i_bit_wdata);

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            thr_q <= 8'h00;
        end else if (i_sfr_wr && i_sfr_addr == 8'hfa) begin
            thr_q <= i_sfr_wdata;
        end
    end

    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    sequence s_pll_write;
        pll_wr;
    endsequence
    sequence s_temp_accept;
        o_temp_req && i_temp_conv.ack;
    endsequence

    property p_pll; s_pll_write |=> o_pll_fault_clr; endproperty
    a_pll: assert property (p_pll) else $error("pll clear pulse missing");
    property p_pll_cause; o_pll_fault_clr |-> $past(pll_wr); endproperty
    a_pll_cause: assert property (p_pll_cause) else $error("pll clear without write");
    property p_temp_ack; s_temp_accept |=> !o_temp_req; endproperty
    a_temp_ack: assert property (p_temp_ack) else $error("request kept after accept");
    property p_temp_hold; o_temp_req && !i_temp_conv.ack && !start_wr |=> o_temp_req; endproperty
    a_temp_hold: assert property (p_temp_hold) else $error("request dropped early");
    property p_irq_cause; o_temp_irq |-> $past(i_temp_conv.done); endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without done");
    property p_batt_cause; o_low_battery_flag_set |-> $past(i_batt_conv.done); endproperty
    a_batt_cause: assert property (p_batt_cause) else $error("battery flag without done");
    property p_vdc_cause; o_voltage_change_flag_set |-> $past(i_vdc_conv.done); endproperty
    a_vdc_cause: assert property (p_vdc_cause) else $error("voltage flag without done");
    property p_batt_low; i_batt_conv.done && i_batt_conv.result < thr_q |=> o_low_battery_flag_set; endproperty
    a_batt_low: assert property (p_batt_low) else $error("low battery missed");
    property p_irq_pulse; o_temp_irq |=> !o_temp_irq; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than one cycle");
    property p_bit_zero; !(i_bit_addr inside {[8'hd8:8'hda]}) |=> !o_bit_rdata; endproperty
    a_bit_zero: assert property (p_bit_zero) else $error("reserved bit reads one");
endmodule // hac_top_chk

bind hac_top hac_top_chk #(.MINUTE_CYCLES(MINUTE_CYCLES)) hac_top_chk_i (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata),
    .i_sfr_wr(i_sfr_wr), .i_bit_addr(i_bit_addr), .i_bit_wdata(i_bit_wdata), .i_bit_wr(i_bit_wr),
    .i_temp_conv(i_temp_conv), .i_batt_conv(i_batt_conv), .i_vdc_conv(i_vdc_conv),
    .o_bit_rdata(o_bit_rdata), .o_temp_req(o_temp_req), .o_temp_irq(o_temp_irq),
    .o_low_battery_flag_set(o_low_battery_flag_set),
    .o_voltage_change_flag_set(o_voltage_change_flag_set), .o_pll_fault_clr(o_pll_fault_clr)
);

/* bench/hac_top_tb.sv */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module hac_top_tb;
    localparam logic [7:0] GO_A [3] = '{8'hd9, 8'hd8, 8'hda};
    localparam logic [7:0] RW_A [6] = '{8'hd7, 8'hdf, 8'hef, 8'hf3, 8'hf9, 8'hfa};
    localparam logic [7:0] RW_M [6] = '{8'hff, 8'hff, 8'hff, 8'h3f, 8'h3f, 8'hff};
    logic i_mclk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, bit_addr = 8'h00;
    logic sfr_wr = 1'b0, bit_wdata = 1'b0, bit_wr = 1'b0;
    logic [7:0] sfr_rdata;
    logic bit_rdata, pll_clr, e;
    logic [2:0] req, ev;
    hac_pkg::hac_conv_in_s conv [3];
    logic [7:0] res [3] = '{8'h00, 8'h00, 8'h00};
    logic [3:0] ack_dly = 4'h0, conv_dly = 4'h0;
    logic [7:0] last [3];
    logic [7:0] dcfg = 8'h00, thr = 8'h00, v, d;
    logic [2:0] code;
    integer seed = 32'h8b956527;
    int fail_count = 0, check_count = 0;

    hac_top #(.MINUTE_CYCLES(36'h28)) hac_top_i (
        .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_sfr_addr(sfr_addr), .i_sfr_wdata(sfr_wdata),
        .i_sfr_wr(sfr_wr), .i_bit_addr(bit_addr), .i_bit_wdata(bit_wdata), .i_bit_wr(bit_wr),
        .i_temp_conv(conv[0]), .i_batt_conv(conv[1]), .i_vdc_conv(conv[2]),
        .o_sfr_rdata(sfr_rdata), .o_bit_rdata(bit_rdata), .o_temp_req(req[0]), .o_batt_req(req[1]),
        .o_vdc_req(req[2]), .o_temp_irq(ev[0]), .o_low_battery_flag_set(ev[1]),
        .o_voltage_change_flag_set(ev[2]), .o_pll_fault_clr(pll_clr));

    for (genvar g = 0; g < 3; g++) begin : g_ch
        hac_conv_model hac_conv_model_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_req(req[g]),
            .i_ack_dly(ack_dly), .i_conv_dly(conv_dly), .i_result(res[g]), .o_conv(conv[g]));
    end

    initial forever #5 i_mclk = ~i_mclk;

    function automatic logic hit(input int ch, input logic [7:0] x);
        logic [2:0] c;
        logic [7:0] df;
        c = (ch == 0) ? dcfg[5:3] : dcfg[2:0];
        df = (x > last[ch]) ? x - last[ch] : last[ch] - x;
        if (ch == 1) return x < thr;
        return (c == 3'h7) || (c != 3'h0 && df > 8'(c));
    endfunction

    task automatic sfr_write(input logic [7:0] a, input logic [7:0] w);
        @(negedge i_mclk);
        {sfr_addr, sfr_wdata, sfr_wr} = {a, w, 1'b1};
        if (a == 8'hf3) dcfg = w;
        if (a == 8'hfa) thr = w;
        @(negedge i_mclk);
        sfr_wr = 1'b0;
    endtask

    task automatic sfr_check(input logic [7:0] a, input logic [7:0] x);
        @(negedge i_mclk);
        sfr_addr = a;
        @(negedge i_mclk);
        `CHK("sfr_rdata", x, sfr_rdata)
    endtask

    task automatic bit_write(input logic [7:0] a, input logic b);
        @(negedge i_mclk);
        {bit_addr, bit_wdata, bit_wr} = {a, b, 1'b1};
        @(negedge i_mclk);
        bit_wr = 1'b0;
    endtask

    task automatic bit_check(input logic [7:0] a, input logic x);
        @(negedge i_mclk);
        bit_addr = a;
        @(negedge i_mclk);
        `CHK("bit_rdata", x, bit_rdata)
    endtask

    task automatic wait_done(input int ch);
        int n = 0;
        do begin
            @(posedge i_mclk);
            n++;
        end while (conv[ch].done !== 1'b1 && n < 400);
        if (n >= 400) fail_count++;
        @(negedge i_mclk);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge i_mclk);
        fail_count++;
        results();
    end

    initial begin
        repeat (10) @(posedge i_mclk);
        @(negedge i_mclk);
        i_rst_b = 1'b1;
        foreach (RW_A[i]) sfr_check(RW_A[i], 8'h00);
        sfr_check(8'hd8, 8'h00);
        sfr_check(8'h80, 8'h00);
        for (int i = 0; i < 8; i++) bit_check(8'hd8 + 8'(i), 1'b0);
        repeat (100) @(negedge i_mclk);
        `CHK("req_idle", 3'h0, req)
        foreach (RW_A[i]) begin
            d = (i == 4) ? 8'hc0 : 8'($random(seed));
            sfr_write(RW_A[i], d);
            sfr_check(RW_A[i], d & RW_M[i]);
        end
        sfr_write(8'hf3, 8'h00);
        sfr_write(8'hd8, 8'h80);
        `CHK("pll_clr", 1'b1, pll_clr)
        bit_write(8'hdf, 1'b1);
        `CHK("pll_clr", 1'b1, pll_clr)
        sfr_check(8'hd8, 8'h00);
        for (int ch = 0; ch < 3; ch++) begin
            res[ch] = 8'h40 + 8'($random(seed) & 32'h7f);
            ack_dly = 4'h4;
            conv_dly = 4'($random(seed) & 32'h3);
            bit_write(GO_A[ch], 1'b1);
            bit_check(GO_A[ch], 1'b1);
            wait_done(ch);
            `CHK("single_event", 1'b1, ev[ch])
            last[ch] = res[ch];
            bit_check(GO_A[ch], 1'b0);
            sfr_check(RW_A[ch], res[ch]);
        end
        for (int ch = 0; ch < 3; ch++) begin
            if (ch != 1) sfr_write(8'hf3, 8'h00);
            sfr_write(8'hf9, 8'((32'h3 - ch) << (2 * ch)));
            for (int k = 0; k < 12; k++) begin
                code = 3'(k);
                if (ch == 1) begin
                    sfr_write(8'hfa, 8'($random(seed)));
                    v = (k < 8) ? thr - 8'(k & 1) : 8'($random(seed));
                end else begin
                    sfr_write(8'hf3, (ch == 0) ? {2'b00, code, 3'b000} : {5'b00000, code});
                    v = (k < 8) ? last[ch] + 8'(code) + 8'(k & 1) : 8'($random(seed));
                end
                res[ch] = v;
                ack_dly = 4'($random(seed) & 32'h3);
                conv_dly = 4'($random(seed) & 32'h3);
                e = hit(ch, v);
                wait_done(ch);
                `CHK("bg_event", e, ev[ch])
                if (e) last[ch] = v;
                sfr_check(RW_A[ch], last[ch]);
            end
            sfr_write(8'hf9, 8'h00);
            repeat (60) @(negedge i_mclk);
        end
        results();
    end
endmodule // hac_top_tb
